// ===== hdl/lnvpc_regs.svh
// Purpose: Constants shared by both ends of the voltage PWM chopper link.
// Assumes: core_clk at 100 MHz.
// Notes: Offsets are byte addresses of 32-bit registers on the AHB-Lite port.
`ifndef LNVPC_REGS_SVH
`define LNVPC_REGS_SVH

`define CORE_CLK_MHZ 100

// Controller register offsets.
`define REG_CTRL 8'h00
`define REG_RMS 8'h04
`define REG_RCOIL 8'h08
`define REG_VSUP 8'h0C
`define REG_VBEMF 8'h10
`define REG_STEP 8'h14
`define REG_STATUS 8'h18

// Field positions and reset values.
`define CTRL_EN_BIT 0
`define CTRL_BLANK_LSB 1
`define CTRL_BLANK_MSB 2
`define CTRL_RESET 3'h4
`define STEP_DIR_BIT 0
`define STAT_PHASE_LSB 0
`define STAT_AMPL_LSB 8
`define STAT_BUSY_BIT 31

// PWM timing: base clock equals chopper rate times 2 to the PWM width.
`define PWM_BITS 10
`define PWM_BASE_MHZ 20
`define PWM_DIV (`CORE_CLK_MHZ / `PWM_BASE_MHZ)
`define PWM_MID 10'h200

// Amplitude arithmetic.
`define PEAK_NUM 141
`define PEAK_DEN 100
`define LIMIT_NUM 5
`define LIMIT_DEN 4

// Blank times in ns, rounded up to whole clock cycles.
`define BLANK_T0_NS 600
`define BLANK_T1_NS 900
`define BLANK_T2_NS 1200
`define BLANK_T3_NS 1500
`define NS_TO_CYC(ns) (((ns) * `CORE_CLK_MHZ + 999) / 1000)

// Chopper oscillator period of the driver.
`define OSC_PERIOD_NS 50000
`define OSC_CYC (`OSC_PERIOD_NS * `CORE_CLK_MHZ / 1000)

`endif

// ===== hdl/lnvpc_pkg.sv
// Purpose: Types shared by the chopper controller and driver ends.
// Assumes: Nothing beyond the constants header.
// Notes: Every phase code is legal, so no default is needed on it.
package lnvpc_pkg;

  typedef enum logic [1:0] {
    PH_DECAY = 2'b00,
    PH_BLANK = 2'b01,
    PH_FAULT = 2'b10,
    PH_ON = 2'b11
  } lnvpc_phase_t;

  typedef enum logic {
    DV_IDLE = 1'b0,
    DV_RUN = 1'b1
  } lnvpc_div_t;

endpackage : lnvpc_pkg

// ===== hdl/lnvpc_if.sv
// Purpose: Pins between the PWM controller and the stepper driver.
// Assumes: Both ends run on the same core_clk.
// Notes: All pins are one-way; the limit is a digital stand-in for the analog level.
`timescale 1ns/1ps
`default_nettype none
interface lnvpc_if;
  logic coil_a_polarity;
  logic coil_b_polarity;
  logic coil_a_mixed_decay_n;
  logic coil_b_mixed_decay_n;
  logic blank_sel_lsb;
  logic blank_sel_msb;
  logic [16:0] coil_a_limit;
  logic [16:0] coil_b_limit;

  modport ctrl (
    output coil_a_polarity, coil_b_polarity, coil_a_mixed_decay_n, coil_b_mixed_decay_n,
    output blank_sel_lsb, blank_sel_msb, coil_a_limit, coil_b_limit
  );
  modport drv (
    input coil_a_polarity, coil_b_polarity, coil_a_mixed_decay_n, coil_b_mixed_decay_n,
    input blank_sel_lsb, blank_sel_msb, coil_a_limit, coil_b_limit
  );
endinterface : lnvpc_if
`default_nettype wire

// ===== hdl/lnvpc_drv.sv
// Purpose: Driver end: cycle-by-cycle chopper with digital comparator blanking.
// Assumes: Sense and overcurrent comparator inputs are synchronous to core_clk.
// Notes: Coil B chops half an oscillator period after coil A.
`timescale 1ns/1ps
`default_nettype none
`include "lnvpc_regs.svh"
module lnvpc_drv import lnvpc_pkg::*; #(
  parameter int OSC_PERIOD_CYC = `OSC_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link from the controller
  lnvpc_if.drv link,
  // Comparators: coil current reached target, and low side overcurrent
  input wire logic coil_a_sense_input,
  input wire logic coil_b_sense_input,
  input wire logic coil_a_overcurrent,
  input wire logic coil_b_overcurrent,
  // Bridge control
  output logic coil_a_bridge_on,
  output logic coil_b_bridge_on,
  output logic coil_a_bridge_dir,
  output logic coil_b_bridge_dir,
  output logic coil_a_mixed_decay,
  output logic coil_b_mixed_decay,
  output logic [16:0] coil_a_limit_level,
  output logic [16:0] coil_b_limit_level,
  // Events
  output logic coil_a_fault_pulse,
  output logic coil_b_fault_pulse
);

  function automatic logic [7:0] blank_cycles(input logic [1:0] sel);
    unique case (sel)
      2'b00: blank_cycles = 8'(`NS_TO_CYC(`BLANK_T0_NS));
      2'b01: blank_cycles = 8'(`NS_TO_CYC(`BLANK_T1_NS));
      2'b10: blank_cycles = 8'(`NS_TO_CYC(`BLANK_T2_NS));
      2'b11: blank_cycles = 8'(`NS_TO_CYC(`BLANK_T3_NS));
    endcase
  endfunction : blank_cycles

  logic [15:0] osc_cnt;
  logic [1:0] pol;
  logic [1:0] pol_q;
  logic [1:0] sense;
  logic [1:0] ocur;
  logic [1:0] mixed_n;
  logic [1:0] restart;
  logic [1:0] fault_pulse;
  logic [1:0] mixed_q;
  logic [7:0] blank_cnt [2];
  lnvpc_phase_t phase [2];

  assign pol = {link.coil_b_polarity, link.coil_a_polarity};
  assign sense = {coil_b_sense_input, coil_a_sense_input};
  assign ocur = {coil_b_overcurrent, coil_a_overcurrent};
  assign mixed_n = {link.coil_b_mixed_decay_n, link.coil_a_mixed_decay_n};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      osc_cnt <= 16'h0000;
    end else if (osc_cnt == 16'(OSC_PERIOD_CYC - 1)) begin
      osc_cnt <= 16'h0000;
    end else begin
      osc_cnt <= osc_cnt + 16'h0001;
    end
  end

  // A polarity edge restarts that bridge at once rather than at the oscillator.
  assign restart[0] = (osc_cnt == 16'h0000) || (pol[0] != pol_q[0]); // R16
  assign restart[1] = (osc_cnt == 16'(OSC_PERIOD_CYC / 2)) || (pol[1] != pol_q[1]); // R16

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pol_q <= 2'h0;
      mixed_q <= 2'h0;
    end else begin
      pol_q <= pol;
      mixed_q <= ~mixed_n;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase <= '{PH_DECAY, PH_DECAY};
      blank_cnt <= '{8'h00, 8'h00};
      fault_pulse <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        fault_pulse[i] <= 1'b0;
        if (restart[i]) begin
          phase[i] <= PH_BLANK;
          blank_cnt[i] <= blank_cycles({link.blank_sel_msb, link.blank_sel_lsb}) - 8'h01; // R13
        end else begin
          unique case (phase[i])
            // Comparators are ignored while blanking, so on time never ends sooner.
            PH_BLANK: begin
              if (blank_cnt[i] == 8'h00) begin // R12 R15 R17
                phase[i] <= PH_ON;
              end else begin
                blank_cnt[i] <= blank_cnt[i] - 8'h01;
              end
            end
            PH_ON: begin
              if (ocur[i]) begin // R17
                phase[i] <= PH_FAULT;
                fault_pulse[i] <= 1'b1;
              end else if (sense[i]) begin // R1
                phase[i] <= PH_DECAY;
              end
            end
            PH_DECAY: phase[i] <= PH_DECAY;
            PH_FAULT: phase[i] <= PH_FAULT;
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      coil_a_limit_level <= 17'h00000;
      coil_b_limit_level <= 17'h00000;
    end else begin
      coil_a_limit_level <= link.coil_a_limit;
      coil_b_limit_level <= link.coil_b_limit;
    end
  end

  // Bit 0 of the phase code is the bridge-on flag, so these come from flops.
  assign coil_a_bridge_on = phase[0][0];
  assign coil_b_bridge_on = phase[1][0];
  assign coil_a_bridge_dir = pol_q[0];
  assign coil_b_bridge_dir = pol_q[1];
  assign coil_a_mixed_decay = mixed_q[0];
  assign coil_b_mixed_decay = mixed_q[1];
  assign coil_a_fault_pulse = fault_pulse[0];
  assign coil_b_fault_pulse = fault_pulse[1];

endmodule : lnvpc_drv
`default_nettype wire

// ===== hdl/lnvpc_ctrl.sv
// Purpose: Controller end: sine and cosine voltage PWM on the coil polarity pins.
// Assumes: AHB-Lite single word transfers; driver shares core_clk.
// Notes: Amplitude is recomputed by a short serial divider after each parameter write.
// What the design has to do
// R1 - Driver ends chopper cycle at target current.
// R2 - Half duty means zero mean current.
// R3 - Coil A sine, coil B cosine PWM.
// R4 - PWM resolution 9 to 10 bits.
// R5 - Base clock is chopper rate times 1024.
// R6 - Duty centred on half, plus minus half amplitude.
// R7 - Amplitude is peak current times R over voltage.
// R8 - PWM outputs drive both coil polarity pins.
// R9 - Mixed decay inputs held high, inactive.
// R10 - Current limit set 20-30% above peak.
// R11 - Add offset one to sine for mixed decay.
// R12 - Driver blanks comparators after switching.
// R13 - Two pins choose 0.6 to 1.5 us blank.
// R14 - Use 1.2 us blank time by default.
// R15 - Minimum on time not below blank time.
// R16 - Polarity change restarts that bridge's PWM cycle.
// R17 - Overcurrent ignored during blanking.
// R18 - New duty loaded only at period boundary.
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lnvpc_regs.svh"
module lnvpc_ctrl import lnvpc_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Driver link
  lnvpc_if.ctrl link
);

  localparam logic [7:0] SIN_Q [0:64] = '{
    8'h00, 8'h06, 8'h0D, 8'h13, 8'h19, 8'h1F, 8'h25, 8'h2C, 8'h32, 8'h38, 8'h3E,
    8'h44, 8'h4A, 8'h50, 8'h56, 8'h5C, 8'h62, 8'h67, 8'h6D, 8'h73, 8'h78, 8'h7E,
    8'h83, 8'h88, 8'h8E, 8'h93, 8'h98, 8'h9D, 8'hA2, 8'hA7, 8'hAB, 8'hB0, 8'hB4,
    8'hB9, 8'hBD, 8'hC1, 8'hC5, 8'hC9, 8'hCD, 8'hD0, 8'hD4, 8'hD7, 8'hDB, 8'hDE,
    8'hE1, 8'hE4, 8'hE7, 8'hE9, 8'hEC, 8'hEE, 8'hF0, 8'hF2, 8'hF4, 8'hF6, 8'hF7,
    8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFE, 8'hFF, 8'hFF, 8'hFF
  };

  // Duty of one coil for a microstep phase; 256 phases per electrical turn.
  function automatic logic [9:0] duty_of(input logic [7:0] ph, input logic [9:0] ampl,
                                         input logic en);
    logic [6:0] idx;
    logic [7:0] mag;
    logic [17:0] prod;
    logic [9:0] off;
    idx = ph[6] ? 7'(7'd64 - {1'b0, ph[5:0]}) : {1'b0, ph[5:0]};
    mag = SIN_Q[idx]; // R11
    prod = 18'(ampl) * 18'(mag);
    off = {1'b0, prod[17:9]};
    if (!en) begin
      duty_of = `PWM_MID; // R2
    end else if (ph[7]) begin
      duty_of = `PWM_MID - off; // R6
    end else begin
      duty_of = `PWM_MID + off; // R6
    end
  endfunction : duty_of

  logic ap_wr, ap_rd, rd_done;
  logic [7:0] ap_addr;
  logic [2:0] ctrl_reg;
  logic [15:0] rms, rcoil, vsup, vbemf;
  logic step_pend, step_dir, div_go, param_wr;
  lnvpc_div_t div_st;
  logic [55:0] rem, den_s, trial;
  logic [3:0] bitn;
  logic [10:0] quo;
  logic [9:0] ampl, pwm_cnt, duty_a, duty_b;
  logic [2:0] pre_cnt;
  logic pwm_tick, period_end, pol_a, pol_b;
  logic [7:0] phase, next_phase;
  logic [16:0] limit_ma;

  // Reads take one wait state so a read right after a write sees the new value.
  assign hreadyout = !(ap_rd && !rd_done);
  assign hresp = 1'b0;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready) begin
      ap_wr <= hsel && htrans[1] && hwrite;
      ap_rd <= hsel && htrans[1] && !hwrite;
      ap_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_done <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      rd_done <= ap_rd && !rd_done;
      if (ap_rd && !rd_done) begin
        unique case (ap_addr)
          `REG_CTRL: hrdata <= {29'h0, ctrl_reg};
          `REG_RMS: hrdata <= {16'h0, rms};
          `REG_RCOIL: hrdata <= {16'h0, rcoil};
          `REG_VSUP: hrdata <= {16'h0, vsup};
          `REG_VBEMF: hrdata <= {16'h0, vbemf};
          `REG_STEP: hrdata <= {31'h0, step_dir};
          `REG_STATUS: hrdata <= {(div_st == DV_RUN), 13'h0, ampl, phase};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign param_wr = ap_wr && ((ap_addr == `REG_RMS) || (ap_addr == `REG_RCOIL) ||
                              (ap_addr == `REG_VSUP) || (ap_addr == `REG_VBEMF));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_reg <= `CTRL_RESET; // R14
      rms <= 16'h0000;
      rcoil <= 16'h0000;
      vsup <= 16'h0000;
      vbemf <= 16'h0000;
    end else if (ap_wr) begin
      unique case (ap_addr)
        `REG_CTRL: ctrl_reg <= hwdata[2:0];
        `REG_RMS: rms <= hwdata[15:0];
        `REG_RCOIL: rcoil <= hwdata[15:0];
        `REG_VSUP: vsup <= hwdata[15:0];
        `REG_VBEMF: vbemf <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // A step request waits for the period boundary; a new request wins over the clear.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      step_pend <= 1'b0;
      step_dir <= 1'b0;
    end else if (ap_wr && ap_addr == `REG_STEP) begin
      step_pend <= 1'b1;
      step_dir <= hwdata[`STEP_DIR_BIT];
    end else if (period_end) begin
      step_pend <= 1'b0;
    end
  end

  // Amplitude = rms * 1.41 * R / (V - Vbemf), in units of 1/1024; mA, mOhm, mV.
  assign trial = den_s << bitn;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_go <= 1'b0;
      div_st <= DV_IDLE;
      rem <= 56'h0;
      den_s <= 56'h0;
      bitn <= 4'h0;
      quo <= 11'h000;
      ampl <= 10'h000;
    end else begin
      if (param_wr) begin
        div_go <= 1'b1;
      end else if (div_st == DV_IDLE) begin
        div_go <= 1'b0;
      end
      unique case (div_st)
        DV_IDLE: begin
          if (div_go) begin
            rem <= (56'(rms) * 56'(`PEAK_NUM) * 56'(rcoil)) << 10; // R7
            den_s <= (vsup > vbemf) ?
                     56'(vsup - vbemf) * 56'(`PEAK_DEN * 1000) : 56'h0;
            bitn <= 4'hA;
            quo <= 11'h000;
            div_st <= DV_RUN;
          end
        end
        DV_RUN: begin
          if (den_s == 56'h0) begin
            ampl <= 10'h3FF;
            div_st <= DV_IDLE;
          end else begin
            if (rem >= trial) begin
              rem <= rem - trial;
              quo[bitn] <= 1'b1;
            end
            if (bitn == 4'h0) begin
              div_st <= DV_IDLE;
            end else begin
              bitn <= bitn - 4'h1;
            end
          end
        end
      endcase
      if (div_st == DV_RUN && den_s != 56'h0 && bitn == 4'h0) begin
        ampl <= (quo[10] || (rem >= trial && 1'b0)) ? 10'h3FF :
                {quo[9:1], (rem >= trial)};
      end
    end
  end

  // Limit sits 25 percent over peak so it only trips on a fault.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      limit_ma <= 17'h00000;
    end else begin
      limit_ma <= 17'((24'(rms) * 24'(`PEAK_NUM) / 24'(`PEAK_DEN)) * 24'(`LIMIT_NUM) /
                      24'(`LIMIT_DEN)); // R10
    end
  end

  assign pwm_tick = (pre_cnt == 3'(`PWM_DIV - 1));
  assign period_end = pwm_tick && (pwm_cnt == 10'h3FF);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pre_cnt <= 3'h0;
      pwm_cnt <= 10'h000;
    end else begin
      pre_cnt <= pwm_tick ? 3'h0 : pre_cnt + 3'h1; // R5
      if (pwm_tick) begin
        pwm_cnt <= pwm_cnt + 10'h001; // R4
      end
    end
  end

  assign next_phase = !step_pend ? phase : (step_dir ? phase - 8'h01 : phase + 8'h01);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      phase <= 8'h00;
      duty_a <= `PWM_MID;
      duty_b <= `PWM_MID;
    end else if (period_end) begin // R18
      phase <= next_phase;
      duty_a <= duty_of(next_phase, ampl, ctrl_reg[`CTRL_EN_BIT]); // R3
      duty_b <= duty_of(next_phase + 8'h40, ampl, ctrl_reg[`CTRL_EN_BIT]); // R3
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pol_a <= 1'b0;
      pol_b <= 1'b0;
    end else begin
      pol_a <= pwm_cnt < duty_a; // R8
      pol_b <= pwm_cnt < duty_b; // R8
    end
  end

  assign link.coil_a_polarity = pol_a;
  assign link.coil_b_polarity = pol_b;
  assign link.coil_a_mixed_decay_n = 1'b1; // R9
  assign link.coil_b_mixed_decay_n = 1'b1; // R9
  assign link.blank_sel_lsb = ctrl_reg[`CTRL_BLANK_LSB];
  assign link.blank_sel_msb = ctrl_reg[`CTRL_BLANK_MSB];
  assign link.coil_a_limit = limit_ma;
  assign link.coil_b_limit = limit_ma;

endmodule : lnvpc_ctrl
`default_nettype wire

// ===== verification/lnvpc_properties.sv
// Purpose: Pin-level checks on the link between the PWM controller and the driver.
// Assumes: One clock; rst_n synchronous and active low.
// Notes: Duties never reach 0 or full scale, so each polarity pin rises once a period.
`timescale 1ns/1ps
`default_nettype none
module lnvpc_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link pins
  input wire logic coil_a_polarity,
  input wire logic coil_b_polarity,
  input wire logic coil_a_mixed_decay_n,
  input wire logic coil_b_mixed_decay_n,
  input wire logic blank_sel_lsb,
  input wire logic blank_sel_msb,
  input wire logic [16:0] coil_a_limit,
  input wire logic [16:0] coil_b_limit
);
  localparam int PERIOD = 5120;
  logic [12:0] gap_a;
  logic [12:0] gap_b;
  logic seen_a;
  logic seen_b;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Cycles since the last rise; the first rise after reset has no reference.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_a <= 13'h0000;
      seen_a <= 1'b0;
    end else if ($rose(coil_a_polarity)) begin
      gap_a <= 13'h0001;
      seen_a <= 1'b1;
    end else if (gap_a != 13'h1FFF) begin
      gap_a <= gap_a + 13'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_b <= 13'h0000;
      seen_b <= 1'b0;
    end else if ($rose(coil_b_polarity)) begin
      gap_b <= 13'h0001;
      seen_b <= 1'b1;
    end else if (gap_b != 13'h1FFF) begin
      gap_b <= gap_b + 13'h0001;
    end
  end

  sequence s_rise_a;
    $rose(coil_a_polarity);
  endsequence
  sequence s_rise_b;
    $rose(coil_b_polarity);
  endsequence

  property p_mixed_off;
    coil_a_mixed_decay_n && coil_b_mixed_decay_n;
  endproperty
  a_mixed_off: assert property (p_mixed_off) else $error("mixed decay pin active");
  property p_limit_equal;
    coil_a_limit == coil_b_limit;
  endproperty
  a_limit_equal: assert property (p_limit_equal) else $error("coil limits differ");
  property p_blank_reset;
    $rose(rst_n) |-> !blank_sel_lsb && blank_sel_msb;
  endproperty
  a_blank_reset: assert property (p_blank_reset) else $error("blank pins not 1.2 us");
  property p_period_a;
    s_rise_a |-> !seen_a || gap_a == PERIOD;
  endproperty
  a_period_a: assert property (p_period_a) else $error("coil A rise off period");
  property p_period_b;
    s_rise_b |-> !seen_b || gap_b == PERIOD;
  endproperty
  a_period_b: assert property (p_period_b) else $error("coil B rise off period");
  property p_toggle_a;
    seen_a |-> gap_a <= PERIOD;
  endproperty
  a_toggle_a: assert property (p_toggle_a) else $error("coil A pin stuck");
  property p_toggle_b;
    seen_b |-> gap_b <= PERIOD;
  endproperty
  a_toggle_b: assert property (p_toggle_b) else $error("coil B pin stuck");
  property p_quad;
    s_rise_a |-> s_rise_b;
  endproperty
  a_quad: assert property (p_quad) else $error("coil PWMs not on one base");
endmodule : lnvpc_properties
`default_nettype wire

// ===== verification/lnvpc_test.sv
// Purpose: Self-checking bench joining controller and driver through the link.
// Assumes: Driver oscillator shortened to 200 cycles to keep the run short.
// Notes: Pulses lengthened by a polarity restart are skipped rather than judged.
`timescale 1ns/1ps
`default_nettype none
module lnvpc_test import lnvpc_pkg::*; ;
  typedef struct {
    string what;
    logic [31:0] val;
  } lnvpc_exp_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic sense_a = 1'b1;
  logic sense_b = 1'b0;
  logic over_a = 1'b0;
  logic over_b = 1'b1;
  logic coil_a_bridge_on;
  logic coil_b_bridge_on;
  logic coil_a_fault_pulse;
  logic coil_b_fault_pulse;
  logic [16:0] coil_a_limit_level;
  logic [16:0] coil_b_limit_level;
  logic [1:0] dir;
  logic [1:0] mixd;
  logic rd_pend = 1'b0;
  lnvpc_exp_t exp_q[$];
  lnvpc_exp_t e;
  logic [31:0] wq[3][$];
  int cnt[3] = '{default: 0};
  logic [2:0] dirty = 3'h0;
  logic [2:0] pol_q = 3'h0;
  logic [2:0] lvl;
  logic [2:0] flt;
  logic [2:0] pol;
  string names[3] = '{"on time a", "on time b", "coil b high time"};
  int fail_count = 0;
  int n_tests = 0;

  always #5 core_clk = ~core_clk;

  lnvpc_if link();
  lnvpc_ctrl lnvpc_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link));
  lnvpc_drv #(.OSC_PERIOD_CYC(200)) lnvpc_drv_inst (.core_clk(core_clk), .rst_n(rst_n),
    .link(link), .coil_a_sense_input(sense_a), .coil_b_sense_input(sense_b),
    .coil_a_overcurrent(over_a), .coil_b_overcurrent(over_b),
    .coil_a_bridge_on(coil_a_bridge_on), .coil_b_bridge_on(coil_b_bridge_on),
    .coil_a_bridge_dir(dir[0]), .coil_b_bridge_dir(dir[1]), .coil_a_mixed_decay(mixd[0]),
    .coil_b_mixed_decay(mixd[1]), .coil_a_limit_level(coil_a_limit_level),
    .coil_b_limit_level(coil_b_limit_level),
    .coil_a_fault_pulse(coil_a_fault_pulse), .coil_b_fault_pulse(coil_b_fault_pulse));
  lnvpc_properties lnvpc_properties_inst (.core_clk(core_clk), .rst_n(rst_n),
    .coil_a_polarity(link.coil_a_polarity), .coil_b_polarity(link.coil_b_polarity),
    .coil_a_mixed_decay_n(link.coil_a_mixed_decay_n),
    .coil_b_mixed_decay_n(link.coil_b_mixed_decay_n),
    .blank_sel_lsb(link.blank_sel_lsb), .blank_sel_msb(link.blank_sel_msb),
    .coil_a_limit(link.coil_a_limit), .coil_b_limit(link.coil_b_limit));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, addr};
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask : ahb

  task automatic rd(input string what, input logic [7:0] addr, input logic [31:0] exp);
    exp_q.push_back('{what, exp});
    ahb(1'b0, addr, 32'h00000000);
  endtask : rd

  task automatic results();
    $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // Read data is judged at the data-phase edge where hreadyout is high.
  always @(posedge core_clk) begin
    if (hreadyout === 1'b1) begin
      if (rd_pend && exp_q.size() > 0) begin
        e = exp_q.pop_front();
        chk(e.what, e.val, hrdata);
      end
      rd_pend <= hsel && htrans[1] && !hwrite;
    end
  end

  // Width of each high pulse, with the fault flag seen at its end in bit 16.
  always @(posedge core_clk) begin
    lvl = {link.coil_b_polarity, coil_b_bridge_on, coil_a_bridge_on};
    flt = {1'b0, coil_b_fault_pulse, coil_a_fault_pulse};
    pol = {1'b0, link.coil_b_polarity, link.coil_a_polarity};
    for (int i = 0; i < 3; i++) begin
      if (lvl[i] === 1'b1) begin
        cnt[i]++;
        if (pol[i] !== pol_q[i]) begin
          dirty[i] = 1'b1;
        end
      end else begin
        if (cnt[i] > 0 && !dirty[i] && wq[i].size() > 0) begin
          chk(names[i], wq[i].pop_front(), {15'h0000, flt[i], cnt[i][15:0]});
          if (i < 2) begin
            chk("bridge dir", {31'h0, pol_q[i]}, {31'h0, dir[i[0]]});
          end
        end
        cnt[i] = 0;
        dirty[i] = 1'b0;
      end
    end
    pol_q = pol;
  end

  initial begin
    logic [7:0] ph;
    logic d;
    void'($urandom(50866));
    ph = 8'h00;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    wq[2].push_back(32'h00000A00);
    rd("ctrl reset", 8'h00, 32'h00000004);
    chk("blank pins reset", 32'h00000002, {link.blank_sel_msb, link.blank_sel_lsb});
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    rd("unmapped", 8'h20, 32'h00000000);
    for (int s = 0; s < 4; s++) begin
      ahb(1'b1, 8'h00, 32'(s << 1));
      repeat (400) @(posedge core_clk);
      chk("blank pins", 32'(s), {link.blank_sel_msb, link.blank_sel_lsb});
      wq[0].push_back(32'(61 + 30 * s));
      wq[1].push_back(32'h00010000 + 32'(61 + 30 * s));
      repeat (400) @(posedge core_clk);
    end
    ahb(1'b1, 8'h04, 32'h000003E8);
    ahb(1'b1, 8'h08, 32'h00001964);
    ahb(1'b1, 8'h0C, 32'h00002EE0);
    ahb(1'b1, 8'h10, 32'h00000000);
    ahb(1'b1, 8'h00, 32'h00000005);
    repeat (50) @(posedge core_clk);
    rd("status ampl", 8'h18, 32'h00030E00);
    chk("limit", 32'h000006E2, {15'h0000, coil_a_limit_level});
    chk("limit b", 32'h000006E2, {15'h0000, coil_b_limit_level});
    chk("mixed decay", 32'h00000000, {30'h0, mixd});
    repeat (10300) @(posedge core_clk);
    wq[2].push_back(32'h00001199);
    repeat (5200) @(posedge core_clk);
    ahb(1'b1, 8'h10, 32'h00002EE0 + $urandom_range(5000, 0));
    for (int k = 0; k < 3; k++) begin
      d = 1'($urandom_range(1, 0));
      ahb(1'b1, 8'h14, {31'h00000000, ~d});
      ahb(1'b1, 8'h14, {31'h00000000, d});
      ph = d ? ph - 8'h01 : ph + 8'h01;
      repeat (5300) @(posedge core_clk);
      rd("status step", 8'h18, {14'h0000, 10'h3FF, ph});
    end
    repeat (20) @(posedge core_clk);
    chk("pending notes", 32'h00000000,
      32'(exp_q.size() + wq[0].size() + wq[1].size() + wq[2].size()));
    results();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    results();
  end
endmodule : lnvpc_test
`default_nettype wire
